/* File: rtc_pkg.sv */
/*
 * Constants for the real-time clock control block: register offsets,
 * control bit positions, reset values and timing counts.
 * Assumes a 50 MHz core clock and an 8-bit register port.
 */
package rtc_pkg;
   localparam int CLK_MHZ = 50;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int TIMER_W = 32;
   // Register offsets
   localparam logic [7:0] HOLD_BASE = 8'h00;
   localparam logic [7:0] CTRL_ADDR = 8'h04;
   localparam logic [7:0] ALARM_BASE = 8'h08;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'h0C;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h0D;
   localparam int BYTES = 4;
   // Control register bit positions
   localparam int B_OSC_POWER = 7;
   localparam int B_MCD_ON = 6;
   localparam int B_OSC_FAIL = 5;
   localparam int B_RUN = 4;
   localparam int B_ALARM_ON = 3;
   localparam int B_ALARM_AR = 2;
   localparam int B_LOAD = 1;
   localparam int B_SNAP = 0;
   // Interrupt status bit positions
   localparam int I_ALARM = 0;
   localparam int I_FAIL = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
   // Missing-clock timeout: time in microseconds, then cycles
   localparam int MISS_TIME_US = 100;
   localparam int MISS_CYCLES = MISS_TIME_US * CLK_MHZ;
endpackage : rtc_pkg

/* File: rtc_timer_core.sv */
/*
 * 32-bit timer with alarm compare and auto-reset, stepped by a one-cycle
 * oscillator tick enable.
 * Assumes load and capture pulses are one core cycle long.
 */
module rtc_timer_core (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic run_in,
   input wire logic alarm_on_in,
   input wire logic autoreset_in,
   input wire logic alarm_clear_in,
   input wire logic load_in,
   input wire logic [31:0] load_value_in,
   input wire logic [31:0] match_in,
   output logic [31:0] count_out,
   output logic alarm_flag_out
);
   logic reset_arm;
   logic next_reset_arm;
   logic [31:0] next_count;
   logic next_alarm;
   wire logic hit = alarm_on_in && run_in && (count_out == match_in);

   // Count, hold, load and auto-reset clear
   assign next_count = load_in ? load_value_in :
      (tick_in && run_in) ? (reset_arm ? rtc_pkg::TIMER_RESET :
      count_out + 32'h0000_0001) : count_out;
   // Flag lives one tick; enable write drops it
   assign next_alarm = alarm_clear_in ? 1'b0 :
      tick_in ? hit : alarm_flag_out;
   // Arm the clear on the tick where the flag falls
   assign next_reset_arm = (tick_in && run_in) ?
      (alarm_flag_out && autoreset_in) : reset_arm;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         count_out <= rtc_pkg::TIMER_RESET;
         alarm_flag_out <= 1'b0;
         reset_arm <= 1'b0;
      end else begin
         count_out <= next_count;
         alarm_flag_out <= next_alarm;
         reset_arm <= next_reset_arm;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   count_inc_a: assert property (tick_in && run_in && !reset_arm && !load_in
      |=> count_out == $past(count_out) + 32'h0000_0001)
      else $error("timer did not step on tick");
   match_a: assert property (tick_in && hit && !alarm_clear_in
      |=> alarm_flag_out)
      else $error("alarm not raised on match");
   autoreset_a: assert property (tick_in && run_in && reset_arm && !load_in
      |=> count_out == 32'h0000_0000)
      else $error("auto-reset did not clear timer");
endmodule : rtc_timer_core

/* File: rtc_control.sv */
/*
 * Control and status logic of a real-time clock: oscillator power and
 * missing-clock detector, timer run, alarm, auto-reset, load and capture
 * handshakes with holding bytes, and an event interrupt.
 * Assumes the oscillator level input is synchronous to the core clock and
 * that a register master drives one-cycle strobes.
 */
//
// Notes on behaviour
// - Oscillator powered only while bit 7 set.
// - Missing-clock detector runs while bits 6 and 7 set.
// - Detector timeout sets oscillator-fail flag bit 5.
// - Timer counts while bit 4 set, holds otherwise.
// - Alarm active only while bit 3 set.
// - Writing alarm enable clears alarm flag.
// - Bit 2 reads the alarm event flag.
// - Bit 2 write stores auto-reset selection.
// - Bit 1 starts load; cleared when done.
// - Bit 0 starts snapshot; cleared when done.
// - Alarm flag lasts at most one oscillator cycle.
// - Running timer steps by one per cycle.
// - Alarm fires when timer equals match value.
// - Auto-reset zeroes timer two cycles after alarm.
// - Detector times out after 100 us stuck.
module rtc_control #(
   parameter int MISS_CYCLES = rtc_pkg::MISS_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic osc_level_in,
   output logic osc_power_out,
   output logic missing_clk_detect_out,
   output logic alarm_event_out,
   output logic osc_fail_event_out,
   output logic irq_out
);
   logic [7:0] rtc_control_q;
   logic [7:0] holding [rtc_pkg::BYTES];
   logic [7:0] match_b [rtc_pkg::BYTES];
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic osc_prev;
   logic [15:0] stuck_cnt;
   logic timeout;
   logic alarm_prev;
   logic [31:0] count;
   logic alarm_flag;
   logic [7:0] next_ctrl;
   logic [7:0] next_stat;
   logic [7:0] next_rdata;

   // Address decode helper shared by both byte banks
   function automatic logic in_bank(input logic [7:0] a,
                                    input logic [7:0] base);
      in_bank = (a >= base) && (a < base + 8'h04);
   endfunction : in_bank

   wire logic [1:0] byte_sel = addr_in[1:0];
   wire logic ctrl_wr = wr_in && (addr_in == rtc_pkg::CTRL_ADDR);
   wire logic hold_wr = wr_in && in_bank(addr_in, rtc_pkg::HOLD_BASE);
   wire logic match_wr = wr_in && in_bank(addr_in, rtc_pkg::ALARM_BASE);
   wire logic stat_wr = wr_in && (addr_in == rtc_pkg::IRQ_STAT_ADDR);
   wire logic mask_wr = wr_in && (addr_in == rtc_pkg::IRQ_MASK_ADDR);

   // Control bits fanned out
   wire logic osc_on = rtc_control_q[rtc_pkg::B_OSC_POWER];
   wire logic mcd_on = rtc_control_q[rtc_pkg::B_MCD_ON];
   wire logic run = rtc_control_q[rtc_pkg::B_RUN];
   wire logic alarm_on = rtc_control_q[rtc_pkg::B_ALARM_ON];
   wire logic autoreset = rtc_control_q[rtc_pkg::B_ALARM_AR];
   wire logic load_go = rtc_control_q[rtc_pkg::B_LOAD];
   wire logic snap_go = rtc_control_q[rtc_pkg::B_SNAP];

   // Oscillator edge is the slow-rate tick; none while unpowered
   wire logic osc_tick = osc_on && osc_level_in && !osc_prev;
   wire logic [31:0] hold_word = {holding[3], holding[2],
                                  holding[1], holding[0]};
   wire logic [31:0] match_word = {match_b[3], match_b[2],
                                   match_b[1], match_b[0]};

   assign osc_power_out = osc_on;
   assign missing_clk_detect_out = mcd_on;
   assign alarm_event_out = alarm_flag;
   assign osc_fail_event_out = rtc_control_q[rtc_pkg::B_OSC_FAIL];
   assign irq_out = |(irq_stat & irq_mask);

   // Control register update; hardware clears the request bits after
   // one cycle, so a request reads back busy at most once
   always_comb begin
      next_ctrl = rtc_control_q;
      next_ctrl[rtc_pkg::B_LOAD] = 1'b0;
      next_ctrl[rtc_pkg::B_SNAP] = 1'b0;
      if (ctrl_wr) begin
         next_ctrl = wdata_in;
      end
      // Timeout wins over a software clear in the same cycle
      if (timeout) begin
         next_ctrl[rtc_pkg::B_OSC_FAIL] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rtc_control_q <= rtc_pkg::CTRL_RESET;
      end else begin
         rtc_control_q <= next_ctrl;
      end
   end

   // Holding bytes: software writes, or a whole-word snapshot
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < rtc_pkg::BYTES; i++) begin
            holding[i] <= 8'h00;
         end
      end else if (snap_go) begin
         for (int i = 0; i < rtc_pkg::BYTES; i++) begin
            holding[i] <= count[8*i +: 8];
         end
      end else if (hold_wr) begin
         holding[byte_sel] <= wdata_in;
      end
   end

   // Alarm match bytes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < rtc_pkg::BYTES; i++) begin
            match_b[i] <= 8'h00;
         end
      end else if (match_wr) begin
         match_b[byte_sel] <= wdata_in;
      end
   end

   // Missing-clock detector: counts core cycles with a stuck level.
   // Only armed while the oscillator is powered, so an off oscillator
   // does not flood the fail flag.
   wire logic mcd_armed = mcd_on && osc_on;
   wire logic osc_moved = osc_level_in != osc_prev;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         osc_prev <= 1'b0;
         stuck_cnt <= 16'h0000;
         timeout <= 1'b0;
      end else begin
         osc_prev <= osc_level_in;
         timeout <= 1'b0;
         if (!mcd_armed || osc_moved) begin
            stuck_cnt <= 16'h0000;
         end else if (stuck_cnt == 16'(MISS_CYCLES)) begin
            timeout <= 1'b1;
            stuck_cnt <= 16'h0000;
         end else begin
            stuck_cnt <= stuck_cnt + 16'h0001;
         end
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   wire logic alarm_rise = alarm_flag && !alarm_prev;
   always_comb begin
      next_stat = irq_stat;
      if (stat_wr) begin
         next_stat = irq_stat & ~wdata_in;
      end
      if (alarm_rise) begin
         next_stat[rtc_pkg::I_ALARM] = 1'b1;
      end
      if (timeout) begin
         next_stat[rtc_pkg::I_FAIL] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_stat <= 8'h00;
         irq_mask <= rtc_pkg::MASK_RESET;
         alarm_prev <= 1'b0;
      end else begin
         irq_stat <= next_stat;
         alarm_prev <= alarm_flag;
         if (mask_wr) begin
            irq_mask <= wdata_in;
         end
      end
   end

   // Read mux; bit 2 of control shows the alarm flag, not auto-reset
   always_comb begin
      next_rdata = 8'h00;
      if (addr_in == rtc_pkg::CTRL_ADDR) begin
         next_rdata = rtc_control_q;
         next_rdata[rtc_pkg::B_ALARM_AR] = alarm_flag;
      end else if (in_bank(addr_in, rtc_pkg::HOLD_BASE)) begin
         next_rdata = holding[byte_sel];
      end else if (in_bank(addr_in, rtc_pkg::ALARM_BASE)) begin
         next_rdata = match_b[byte_sel];
      end else if (addr_in == rtc_pkg::IRQ_STAT_ADDR) begin
         next_rdata = irq_stat;
      end else if (addr_in == rtc_pkg::IRQ_MASK_ADDR) begin
         next_rdata = irq_mask;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_in ? next_rdata : 8'h00;
      end
   end

   rtc_timer_core u_timer (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_in(osc_tick),
      .run_in(run),
      .alarm_on_in(alarm_on),
      .autoreset_in(autoreset),
      .alarm_clear_in(ctrl_wr),
      .load_in(load_go),
      .load_value_in(hold_word),
      .match_in(match_word),
      .count_out(count),
      .alarm_flag_out(alarm_flag)
   );

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence load_start;
      ctrl_wr && wdata_in[rtc_pkg::B_LOAD];
   endsequence
   sequence load_busy_then_done;
      load_go ##1 (!load_go && count == $past(hold_word));
   endsequence
   sequence snap_start;
      ctrl_wr && wdata_in[rtc_pkg::B_SNAP];
   endsequence

   osc_power_a: assert property (ctrl_wr
      |=> osc_power_out == $past(wdata_in[7]))
      else $error("oscillator power does not follow bit 7");
   mcd_enable_a: assert property (ctrl_wr
      |=> missing_clk_detect_out == $past(wdata_in[6]))
      else $error("detector enable does not follow bit 6");
   fail_set_a: assert property (timeout |=> osc_fail_event_out)
      else $error("timeout did not set fail flag");
   run_hold_a: assert property (!run && !load_go
      |=> $stable(count))
      else $error("stopped timer changed");
   alarm_clear_a: assert property (ctrl_wr |=> !alarm_flag)
      else $error("enable write left alarm flag set");
   alarm_off_a: assert property (!alarm_on && !alarm_flag
      |=> !alarm_flag)
      else $error("alarm raised while disabled");
   read_alarm_a: assert property (rd_in && addr_in == rtc_pkg::CTRL_ADDR
      |=> rdata_out[2] == $past(alarm_flag))
      else $error("bit 2 read is not the alarm flag");
   autoreset_wr_a: assert property (ctrl_wr && !load_go
      |=> autoreset == $past(wdata_in[2]))
      else $error("auto-reset not stored");
   load_done_a: assert property (load_start
      |=> load_busy_then_done)
      else $error("load handshake wrong");
   snap_done_a: assert property (snap_start
      |=> snap_go ##1 (!snap_go && hold_word == $past(count)))
      else $error("snapshot handshake wrong");
   alarm_short_a: assert property (alarm_flag && osc_tick && run
      && !load_go |=> !alarm_flag)
      else $error("alarm flag outlived one oscillator cycle");
   stuck_bound_a: assert property (mcd_armed && !osc_moved
      |-> stuck_cnt <= 16'(MISS_CYCLES))
      else $error("detector count overran its limit");
endmodule : rtc_control

/* File: tb_top.sv */
/*
 * Self-checking bench for the real-time clock control block: bus tasks,
 * an integer model of the timer and directed scenarios with random data.
 * Assumes the rtc_pkg constants and a shortened missing-clock count.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MISS = 20;
   localparam logic [7:0] P = 8'h80;
   localparam logic [7:0] MCD = 8'h40;
   localparam logic [7:0] RUN = 8'h10;
   localparam logic [7:0] AON = 8'h08;
   localparam logic [7:0] AR = 8'h04;
   localparam logic [7:0] LD = 8'h02;
   localparam logic [7:0] SN = 8'h01;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic osc_level_in = 1'b0;
   logic [7:0] rdata_out;
   logic osc_power_out;
   logic missing_clk_detect_out;
   logic alarm_event_out;
   logic osc_fail_event_out;
   logic irq_out;
   int err_count = 0;
   int n_compared = 0;
   integer seed = 32'h8bc5;
   logic [31:0] v;
   logic [31:0] got;
   logic [7:0] b;
   int model_cnt;

   // Free-running core clock, 20 ns period
   always #10 core_clk_in = ~core_clk_in;

   rtc_control #(.MISS_CYCLES(MISS)) u_rtc_control (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .osc_level_in(osc_level_in),
      .osc_power_out(osc_power_out),
      .missing_clk_detect_out(missing_clk_detect_out),
      .alarm_event_out(alarm_event_out),
      .osc_fail_event_out(osc_fail_event_out),
      .irq_out(irq_out)
   );

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One-cycle write strobe; the gap before the next strobe is harmless
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask : wr_reg

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd_reg

   task automatic wr32(input logic [7:0] base, input logic [31:0] d);
      for (int i = 0; i < 4; i++) begin
         wr_reg(base + 8'(i), d[8*i +: 8]);
      end
   endtask : wr32

   task automatic rd_hold(output logic [31:0] d);
      logic [7:0] x;
      for (int i = 0; i < 4; i++) begin
         rd_reg(rtc_pkg::HOLD_BASE + 8'(i), x);
         d[8*i +: 8] = x;
      end
   endtask : rd_hold

   // One oscillator period; settled well before the task returns
   task automatic tick;
      @(posedge core_clk_in);
      osc_level_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      osc_level_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
   endtask : tick

   // Load a value, then step through ticks watching the alarm flag
   task automatic alarm_run(input logic [7:0] mode, input int n);
      v = $random(seed);
      wr32(rtc_pkg::HOLD_BASE, v);
      wr_reg(rtc_pkg::CTRL_ADDR, P | LD);
      wr32(rtc_pkg::ALARM_BASE, v + 32'h0000_0002);
      wr_reg(rtc_pkg::CTRL_ADDR, mode);
      for (int k = 1; k <= n; k++) begin
         tick();
         check("alarm flag", alarm_event_out, k == 3);
      end
   endtask : alarm_run

   // Hang guard, far beyond the expected run length
   initial begin
      #2_000_000;
      err_count++;
      end_sim();
   end

   initial begin
      repeat (8) @(posedge core_clk_in);
      rst_in <= 1'b0;
      // Reset values and an unmapped place
      rd_reg(rtc_pkg::CTRL_ADDR, b);
      check("ctrl reset", b, rtc_pkg::CTRL_RESET);
      rd_reg(rtc_pkg::IRQ_MASK_ADDR, b);
      check("mask reset", b, rtc_pkg::MASK_RESET);
      check("irq reset", irq_out, 1'b0);
      wr_reg(8'h20, 8'h5A);
      rd_reg(8'h20, b);
      check("unmapped", b, 8'h00);
      // Oscillator power and detector enables
      wr_reg(rtc_pkg::CTRL_ADDR, P | MCD);
      #1 check("osc power", osc_power_out, 1'b1);
      check("detector on", missing_clk_detect_out, 1'b1);
      wr_reg(rtc_pkg::CTRL_ADDR, 8'h00);
      #1 check("osc power off", osc_power_out, 1'b0);
      check("detector off", missing_clk_detect_out, 1'b0);
      // Load, then snapshot back after scrambling the holding bytes
      v = $random(seed);
      wr32(rtc_pkg::HOLD_BASE, v);
      rd_hold(got);
      check("holding rw", got, v);
      wr_reg(rtc_pkg::CTRL_ADDR, P | LD);
      rd_reg(rtc_pkg::CTRL_ADDR, b);
      check("load done", b, P);
      wr32(rtc_pkg::HOLD_BASE, ~v);
      wr_reg(rtc_pkg::CTRL_ADDR, P | SN);
      rd_reg(rtc_pkg::CTRL_ADDR, b);
      check("snap done", b, P);
      rd_hold(got);
      check("snap value", got, v);
      // Run five ticks, stop, two more ticks must not count
      model_cnt = v;
      wr_reg(rtc_pkg::CTRL_ADDR, P | RUN);
      repeat (5) begin
         tick();
         model_cnt++;
      end
      wr_reg(rtc_pkg::CTRL_ADDR, P);
      repeat (2) tick();
      wr_reg(rtc_pkg::CTRL_ADDR, P | SN);
      rd_hold(got);
      check("count", got, 32'(model_cnt));
      // Alarm without auto-reset, flag read, interrupt and clear
      wr_reg(rtc_pkg::IRQ_MASK_ADDR, 8'h03);
      alarm_run(P | RUN | AON, 3);
      rd_reg(rtc_pkg::CTRL_ADDR, b);
      check("flag read", b, P | RUN | AON | AR);
      check("alarm irq", irq_out, 1'b1);
      rd_reg(rtc_pkg::IRQ_STAT_ADDR, b);
      check("stat alarm", b, 8'h01);
      wr_reg(rtc_pkg::CTRL_ADDR, P);
      @(posedge core_clk_in);
      #1 check("flag cleared", alarm_event_out, 1'b0);
      wr_reg(rtc_pkg::IRQ_STAT_ADDR, 8'h01);
      @(posedge core_clk_in);
      #1 check("irq cleared", irq_out, 1'b0);
      // Auto-reset: flag at tick 3, falls at 4, zero at 5, one at 6
      alarm_run(P | RUN | AON | AR, 6);
      wr_reg(rtc_pkg::CTRL_ADDR, P);
      wr_reg(rtc_pkg::CTRL_ADDR, P | SN);
      rd_hold(got);
      check("auto reset", got, 32'h0000_0001);
      wr_reg(rtc_pkg::IRQ_STAT_ADDR, 8'h01);
      // Stuck oscillator level trips the detector after MISS cycles
      wr_reg(rtc_pkg::CTRL_ADDR, P | MCD);
      repeat (MISS - 3) @(posedge core_clk_in);
      #1 check("no early fail", osc_fail_event_out, 1'b0);
      repeat (8) @(posedge core_clk_in);
      #1 check("fail set", osc_fail_event_out, 1'b1);
      rd_reg(rtc_pkg::CTRL_ADDR, b);
      check("fail bit", b, P | MCD | 8'h20);
      rd_reg(rtc_pkg::IRQ_STAT_ADDR, b);
      check("stat fail", b, 8'h02);
      check("fail irq", irq_out, 1'b1);
      // Software clears the flag itself, detector off in the same write
      wr_reg(rtc_pkg::CTRL_ADDR, P);
      wr_reg(rtc_pkg::IRQ_STAT_ADDR, 8'h02);
      @(posedge core_clk_in);
      #1 check("fail cleared", osc_fail_event_out, 1'b0);
      check("irq idle", irq_out, 1'b0);
      end_sim();
   end
endmodule : tb_top
